//--- dp_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module dp_master_model
  import outcmd_pkg::*;
(
  input wire logic clk,
  output logic image_valid = 1'b0,
  output image_byte_t image_byte = '0,
  output logic image_end = 1'b0
);
  // **
  // Cyclic write
  // **
  task put(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    image_valid <= 1'b1;
    image_byte <= {a, d};
  endtask
  // Idle bus inverted so stale bytes never look valid
  task fin();
    @(posedge clk);
    image_valid <= 1'b0;
    image_byte <= ~image_byte;
    @(posedge clk);
    image_end <= 1'b1;
    @(posedge clk);
    image_end <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- outcmd_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module outcmd_chk
  import outcmd_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic operate,
  input wire logic image_end,
  input wire logic send_start,
  input wire frame_cmd_t send_cmd,
  input wire diag_t diag,
  input wire logic data_exchange
);
  // **
  // Checks
  // **
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_off; !operate |-> ##[1:2] !data_exchange; endproperty
  a_off: assert property (p_off) else $error("off");
  property p_go; $rose(data_exchange) |-> $past(operate); endproperty
  a_go: assert property (p_go) else $error("early");
  property p_snd; send_start |-> $past(image_end) && $past(data_exchange); endproperty
  a_snd: assert property (p_snd) else $error("stray send");
  property p_pre; send_start && !send_cmd.compact |->
    send_cmd.preamble >= PREAMBLE_MIN && send_cmd.preamble <= PREAMBLE_MAX; endproperty
  a_pre: assert property (p_pre) else $error("preamble");
  property p_sel; send_start && send_cmd.compact |-> send_cmd.module_sel != 8'h00; endproperty
  a_sel: assert property (p_sel) else $error("select");
  // Image-driven diagnostics move only on image evaluation
  property p_dg; !$past(image_end) |->
    $stable({diag.lost_output, diag.channel_range, diag.preamble_range, diag.wrong_mode});
  endproperty
  a_dg: assert property (p_dg) else $error("diag");
  property p_ch; $rose(diag.channel_range) |-> !send_start; endproperty
  a_ch: assert property (p_ch) else $error("channel");
  property p_wm; $rose(diag.wrong_mode) |-> !send_start; endproperty
  a_wm: assert property (p_wm) else $error("mode");
  c_snd: cover property (send_start);
  c_cmp: cover property (send_start && send_cmd.compact);
  c_ch: cover property ($rose(diag.channel_range));
endmodule
bind outcmd_decoder outcmd_chk chk_u (.clk, .rstn, .operate, .image_end, .send_start,
  .send_cmd, .diag, .data_exchange);
`default_nettype wire

//--- outcmd_decoder.sv
// Overview of operation
// R01: Accept output image up to 240 bytes
// R02: Bytes 0-5 commands, 6-239 payload
// R03: Master places command bytes first
// R04: Trigger change copies payload, sends frame; the queue here takes the payload of every image, trigger change or not
// R05: Master increments trigger modulo 256
// R06: Non-increment trigger change raises diagnostic
// R07: Control bit 0 clears all diagnostics
// R08: Control bit 2 disables auto detection
// R09: Master writes other control bits zero
// R10: Compact: nonzero select fires module send
// R11: Transparent: channel from byte 3, 0-3
// R12: Transparent: preamble from byte 4, 5-20
// R13: Transparent: byte 5 gives payload count
// R14: Operate, init, Set_Prm, Check_Cfg, exchange
// R15: Any error returns to await parameterization
// R16: Channel above 3 reports diagnostic
// R17: Bad preamble becomes 20, reports diagnostic
// R18: Compact non-manual module reports, no send
// R19: Hold last trigger, compare each image
`timescale 1ns/1ps
`default_nettype none
module outcmd_decoder
  import outcmd_pkg::*;
#(
  parameter int IMAGE_LEN = 240,
  parameter int MODULE_COUNT = 111
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic operate,
  input wire logic set_prm_seen,
  input wire logic check_cfg_seen,
  input wire logic cfg_error,
  input wire logic [7:0] cfg_image_len,
  input wire frame_layout_selector_t frame_layout_selector,
  input wire logic [MODULE_COUNT:1] module_manual,
  input wire logic image_valid,
  input wire image_byte_t image_byte,
  input wire logic image_end,
  input wire logic send_ready,
  input wire logic [7:0] send_addr,
  output logic send_start,
  output frame_cmd_t send_cmd,
  output logic [7:0] send_data,
  output logic detect_enable,
  output diag_t diag,
  output logic data_exchange
);
  initial
  begin
    if (IMAGE_LEN < CMD_BYTES + 1 || IMAGE_LEN > IMAGE_MAX)
      $error("outcmd_decoder: IMAGE_LEN out of range");
    if (MODULE_COUNT < 1 || MODULE_COUNT > 255)
      $error("outcmd_decoder: MODULE_COUNT out of range");
  end

  // ****************************************
  // Start-up sequencing
  // ****************************************
  typedef enum logic [2:0] {
    st_offline,
    st_init,
    st_wait_prm,
    st_wait_cfg,
    st_exchange
  } link_state_t;

  link_state_t state;
  logic cfg_bad;
  logic run_error;

  assign cfg_bad = int'(cfg_image_len) > IMAGE_LEN; // R01
  assign data_exchange = (state == st_exchange);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      state <= st_offline;
    else if (!operate)
      state <= st_offline;
    else
    begin
      case (state)
        st_offline: state <= st_init; // R14
        st_init: state <= st_wait_prm; // R14
        st_wait_prm:
        begin
          if (set_prm_seen)
            state <= st_wait_cfg; // R14
        end
        st_wait_cfg:
        begin
          if (cfg_error || cfg_bad)
            state <= st_wait_prm; // R15
          else if (check_cfg_seen)
            state <= st_exchange; // R14
        end
        st_exchange:
        begin
          if (run_error)
            state <= st_wait_prm; // R15
        end
        default: state <= st_offline;
      endcase
    end
  end

  assign run_error = cfg_error || cfg_bad; // R15

  // ****************************************
  // Command bytes
  // ****************************************
  logic [7:0] trig_new;
  logic [7:0] control;
  logic [7:0] module_sel;
  logic [7:0] channel;
  logic [7:0] preamble;
  logic [7:0] frame_len;
  logic [7:0] trig_last;
  logic trig_known;
  logic in_image;
  logic cmd_byte;

  assign in_image = image_valid && data_exchange && int'(image_byte.addr) < IMAGE_LEN;
  assign cmd_byte = in_image && int'(image_byte.addr) < CMD_BYTES; // R02

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      trig_new <= 8'h00;
      control <= 8'h00;
      module_sel <= 8'h00;
      channel <= 8'h00;
      preamble <= PREAMBLE_SUBST;
      frame_len <= 8'h00;
    end
    else if (cmd_byte)
    begin
      case (image_byte.addr)
        OFS_TRIGGER: trig_new <= image_byte.data;
        OFS_CONTROL: control <= image_byte.data;
        OFS_MODULE: module_sel <= image_byte.data;
        OFS_CHANNEL: channel <= image_byte.data; // R11
        OFS_PREAMBLE: preamble <= image_byte.data; // R12
        OFS_FRAMELEN: frame_len <= image_byte.data; // R13
        default: ;
      endcase
    end
  end

  // Only bits 0 and 2 matter; others are ignored, not trapped
  assign detect_enable = !control[CTL_DETECT_OFF_BIT]; // R08

  // ****************************************
  // Payload into output queue
  // ****************************************
  logic [7:0] pay_addr;

  assign pay_addr = 8'(image_byte.addr - 8'(CMD_BYTES));

  outcmd_queue #(
    .DEPTH(IMAGE_LEN - CMD_BYTES)
  ) u_queue (
    .clk(clk),
    .rstn(rstn),
    .wr_en(in_image && !cmd_byte), // R04
    .wr_addr(pay_addr),
    .wr_data(image_byte.data),
    .rd_en(send_ready),
    .rd_addr(send_addr),
    .rd_data(send_data)
  );

  // ****************************************
  // Trigger evaluation at image end
  // ****************************************
  logic changed;
  logic stepped;
  logic compact;
  logic sel_valid;
  logic sel_manual;
  logic image_done;

  assign image_done = image_end && data_exchange;
  assign changed = trig_known && (trig_new != trig_last); // R19
  assign stepped = (trig_new == 8'(trig_last + TRIGGER_STEP)); // R06
  assign compact = (frame_layout_selector == layout_compact);
  assign sel_valid = (module_sel != 8'h00) && int'(module_sel) <= MODULE_COUNT;
  assign sel_manual = sel_valid && module_manual[module_sel]; // R18

  // First image only sets the last trigger, no send on it
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      trig_last <= 8'h00;
      trig_known <= 1'b0;
    end
    else if (!data_exchange)
      trig_known <= 1'b0;
    else if (image_done)
    begin
      trig_last <= trig_new; // R19
      trig_known <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      send_start <= 1'b0;
      send_cmd <= '0;
    end
    else
    begin
      send_start <= 1'b0;
      if (image_done && changed)
      begin
        send_cmd.compact <= compact;
        send_cmd.module_sel <= module_sel;
        send_cmd.channel <= channel[1:0]; // R11
        send_cmd.length <= frame_len; // R13
        if (preamble < PREAMBLE_MIN || preamble > PREAMBLE_MAX)
          send_cmd.preamble <= PREAMBLE_SUBST; // R17
        else
          send_cmd.preamble <= preamble; // R12
        if (compact)
          send_start <= sel_manual; // R10
        else
          send_start <= (channel <= CHANNEL_MAX); // R04
      end
    end
  end

  // ****************************************
  // Diagnostics
  // ****************************************
  diag_t next_diag;
  logic clear_req;

  assign clear_req = image_done && control[CTL_CLEAR_BIT]; // R07

  always_comb
  begin
    next_diag = '0;
    if (image_done && changed)
    begin
      next_diag.lost_output = !stepped; // R06
      if (!compact)
      begin
        next_diag.channel_range = channel > CHANNEL_MAX; // R16
        next_diag.preamble_range = preamble < PREAMBLE_MIN || preamble > PREAMBLE_MAX; // R17
      end
      else
        next_diag.wrong_mode = (module_sel != 8'h00) && !sel_manual; // R18
    end
    next_diag.bad_config = operate && cfg_bad; // R01
  end

  // New events win over a clear in the same cycle
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      diag <= '0;
    else if (clear_req)
      diag <= next_diag; // R07
    else
      diag <= diag | next_diag;
  end
endmodule
`default_nettype wire

//--- outcmd_pkg.sv
package outcmd_pkg;
  localparam int IMAGE_MAX = 240;
  localparam int CMD_BYTES = 6;
  localparam logic [7:0] OFS_TRIGGER = 8'h00;
  localparam logic [7:0] OFS_CONTROL = 8'h01;
  localparam logic [7:0] OFS_MODULE = 8'h02;
  localparam logic [7:0] OFS_CHANNEL = 8'h03;
  localparam logic [7:0] OFS_PREAMBLE = 8'h04;
  localparam logic [7:0] OFS_FRAMELEN = 8'h05;
  localparam int CTL_CLEAR_BIT = 0;
  localparam int CTL_DETECT_OFF_BIT = 2;
  localparam logic [7:0] CHANNEL_MAX = 8'h03;
  localparam logic [7:0] PREAMBLE_MIN = 8'h05;
  localparam logic [7:0] PREAMBLE_MAX = 8'h14;
  localparam logic [7:0] PREAMBLE_SUBST = 8'h14;
  localparam logic [7:0] TRIGGER_STEP = 8'h01;

  typedef enum logic [0:0] {
    layout_transparent,
    layout_compact
  } frame_layout_selector_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } image_byte_t;

  typedef struct packed {
    logic lost_output;
    logic channel_range;
    logic preamble_range;
    logic wrong_mode;
    logic bad_config;
  } diag_t;

  typedef struct packed {
    logic [1:0] channel;
    logic [7:0] preamble;
    logic [7:0] length;
    logic [7:0] module_sel;
    logic compact;
  } frame_cmd_t;
endpackage

//--- outcmd_queue.sv
`timescale 1ns/1ps
`default_nettype none
module outcmd_queue
  import outcmd_pkg::*;
#(
  parameter int DEPTH = 234
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic rd_en,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data
);
  initial
  begin
    if (DEPTH < 1 || DEPTH > IMAGE_MAX - CMD_BYTES)
      $error("outcmd_queue: DEPTH out of range");
  end

  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk)
  begin
    if (wr_en && int'(wr_addr) < DEPTH)
      mem[wr_addr] <= wr_data;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rd_data <= 8'h00;
    else if (rd_en && int'(rd_addr) < DEPTH)
      rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
  $display("[FAIL] %0t mismatch", $time); end end
module tb
  import outcmd_pkg::*;
;
  logic clk, rstn, operate, set_prm_seen, check_cfg_seen, cfg_error;
  logic image_valid, image_end, send_start, detect_enable, data_exchange;
  logic [7:0] cfg_image_len;
  logic send_ready;
  logic [7:0] send_addr, send_data;
  logic [111:1] module_manual;
  frame_layout_selector_t frame_layout_selector;
  image_byte_t image_byte;
  frame_cmd_t send_cmd;
  diag_t diag;
  int err_total = 0;
  int checks_done = 0;
  dp_master_model m_u (.clk, .image_valid, .image_byte, .image_end);
  outcmd_decoder dut_u (.clk, .rstn, .operate, .set_prm_seen, .check_cfg_seen, .cfg_error,
    .cfg_image_len, .frame_layout_selector, .module_manual, .image_valid, .image_byte,
    .image_end, .send_ready, .send_addr, .send_start, .send_cmd,
    .send_data, .detect_enable, .diag, .data_exchange);
  // **
  // Tasks
  // **
  task results();
    if (err_total == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Lead-in lets the init cycle pass first
  task enter();
    repeat (3) @(posedge clk);
    set_prm_seen <= 1'b1;
    @(posedge clk) set_prm_seen <= 1'b0;
    check_cfg_seen <= 1'b1;
    @(posedge clk) check_cfg_seen <= 1'b0;
    repeat (2) @(posedge clk);
    `CK(data_exchange, 1'b1)
  endtask
  // w packs control, select, channel, preamble
  task img(input logic [7:0] t, input logic [31:0] w, input logic es, input diag_t ed);
    m_u.put(OFS_TRIGGER, t);
    m_u.put(OFS_CONTROL, w[31:24]);
    m_u.put(OFS_MODULE, w[23:16]);
    m_u.put(OFS_CHANNEL, w[15:8]);
    m_u.put(OFS_PREAMBLE, w[7:0]);
    m_u.put(OFS_FRAMELEN, 8'h01);
    m_u.put(8'h06, ~t);
    m_u.fin();
    #1;
    `CK(send_start, es)
    `CK(diag, ed)
  endtask
  // Queue read: one request cycle, data registered one edge later
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    send_ready <= 1'b1;
    send_addr <= a;
    @(posedge clk);
    send_ready <= 1'b0;
    #1;
    `CK(send_data, e)
  endtask
  // **
  // Sequence
  // **
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    #100000;
    err_total++;
    results();
  end
  initial
  begin
    rstn = 1'b0;
    {operate, set_prm_seen, check_cfg_seen, cfg_error} = '0;
    cfg_image_len = 8'hf0;
    frame_layout_selector = layout_transparent;
    module_manual = '0;
    module_manual[3] = 1'b1;
    send_ready = 1'b0;
    send_addr = 8'h00;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk) operate <= 1'b1;
    enter();
    img(8'h01, 32'h00000207, 1'b0, 5'h00);
    img(8'h02, 32'h00000207, 1'b1, 5'h00);
    `CK(send_cmd, {2'h2, 8'h07, 8'h01, 8'h00, 1'b0})
    rd(8'h00, 8'hfd);
    img(8'h03, 32'h00000204, 1'b1, 5'h04);
    `CK(send_cmd.preamble, PREAMBLE_SUBST)
    img(8'h04, 32'h00000407, 1'b0, 5'h0c);
    img(8'h06, 32'h00000107, 1'b1, 5'h1c);
    img(8'h07, 32'h05000114, 1'b1, 5'h00);
    `CK(detect_enable, 1'b0)
    img(8'hff, 32'h01000305, 1'b1, 5'h10);
    img(8'h00, 32'h01000305, 1'b1, 5'h00);
    `CK(detect_enable, 1'b1)
    @(posedge clk) frame_layout_selector <= layout_compact;
    img(8'h01, 32'h00030007, 1'b1, 5'h00);
    `CK(send_cmd.module_sel, 8'h03)
    img(8'h02, 32'h00020007, 1'b0, 5'h02);
    img(8'h03, 32'h01000007, 1'b0, 5'h00);
    @(posedge clk) cfg_image_len <= 8'hf1;
    repeat (3) @(posedge clk);
    `CK(data_exchange, 1'b0)
    `CK(diag.bad_config, 1'b1)
    cfg_image_len <= 8'hf0;
    enter();
    cfg_error <= 1'b1;
    repeat (3) @(posedge clk);
    `CK(data_exchange, 1'b0)
    operate <= 1'b0;
    cfg_error <= 1'b0;
    repeat (2) @(posedge clk);
    `CK(data_exchange, 1'b0)
    operate <= 1'b1;
    enter();
    img(8'h40, 32'h01000207, 1'b0, 5'h00);
    rd(8'h00, 8'hbf);
    results();
  end
endmodule
`default_nettype wire
